// *** include/ioexp_pkg.sv ***
// constants shared by the dual-bank i/o expander design
`default_nettype none
package ioexp_pkg;
  // command codes
  localparam logic [7:0] CMD_NORMAL_OUT = 8'h00;
  localparam logic [7:0] CMD_NORMAL_RISE = 8'h01;
  localparam logic [7:0] CMD_NORMAL_FALL = 8'h02;
  localparam logic [7:0] CMD_SUSPEND_OUT = 8'h03;
  localparam logic [7:0] CMD_SUSPEND_RISE = 8'h04;
  localparam logic [7:0] CMD_SUSPEND_FALL = 8'h05;
  localparam logic [7:0] CMD_PIN_LEVEL = 8'h06;
  localparam logic [7:0] CMD_ADDR_RESAMPLE = 8'h07;
  localparam logic [7:0] CMD_SW_RESET = 8'h08;
  localparam logic [7:0] CMD_MAKER_ID = 8'hfe;
  // register file indices
  localparam logic [2:0] IDX_NORMAL_OUT = 3'h0;
  localparam logic [2:0] IDX_NORMAL_RISE = 3'h1;
  localparam logic [2:0] IDX_NORMAL_FALL = 3'h2;
  localparam logic [2:0] IDX_SUSPEND_OUT = 3'h3;
  localparam logic [2:0] IDX_SUSPEND_RISE = 3'h4;
  localparam logic [2:0] IDX_SUSPEND_FALL = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam int NUM_REGS = 6;
  // values after reset
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] OUT_RST_NCHAN = 8'h00;
  localparam logic [7:0] OUT_RST_PCHAN = 8'hff;
  // alert response address, 7-bit form of 0x19 with read bit
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h20;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] ADDR_SAMPLE_DELAY = 2'h3;
endpackage
`default_nettype wire

// *** logic/pin_edge_detect.sv ***
// pin synchroniser and per-pin edge finder
`default_nettype none
module pin_edge_detect #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstN,
  // raw pins
  input wire logic [WIDTH-1:0] pinRaw,
  // synchronised level and edges
  output logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] riseEv,
  output logic [WIDTH-1:0] fallEv
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] prevLevel;
  logic [2:0] warm;

  // two flops before any logic, then one more to compare against
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= '0;
      pinLevel <= '0;
      prevLevel <= '0;
      warm <= 3'h0;
    end else begin
      warm <= {warm[1:0], 1'b1};
      stage1 <= pinRaw;
      pinLevel <= stage1;
      prevLevel <= pinLevel;
    end
  end

  // edges are found before any masking
  // none until the history is full: the pins' idle level is unknown at reset
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      riseEv <= '0;
      fallEv <= '0;
    end else begin
      riseEv <= pinLevel & ~prevLevel & {WIDTH{warm[2]}};
      fallEv <= ~pinLevel & prevLevel & {WIDTH{warm[2]}};
    end
  end
endmodule
`default_nettype wire

// *** logic/smbus_io_expander.sv ***
// smbus slave i/o expander with normal and suspend register banks
`default_nettype none
module smbus_io_expander import ioexp_pkg::*; #(
  parameter int WIDTH = 8,
  parameter bit PCHAN_VARIANT = 1'b0,
  parameter logic [7:0] MAKER_ID = 8'h5a // arbitrary neutral value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // smbus pins, open drain
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // expander pins, open drain
  input wire logic [WIDTH-1:0] ioIn,
  output logic [WIDTH-1:0] ioOut,
  output logic [WIDTH-1:0] ioOe,
  // control pins
  input wire logic bank_select_suspend_n,
  input wire logic [2:0] addrSelect,
  input wire logic thermalShutdown,
  // alert, active low
  output logic alertN
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_SKIP
  } bus_state_e;

  localparam logic [7:0] OUT_RST = PCHAN_VARIANT ? OUT_RST_PCHAN : OUT_RST_NCHAN;

  // reset synchroniser
  logic rstQ1;
  logic rstN;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstQ1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstQ1 <= 1'b1;
      rstN <= rstQ1;
    end
  end

  // pin synchronisers: first stage read only by the second
  logic sclQ1, sclQ2, sclQ3, sdaQ1, sdaQ2, sdaQ3;
  logic suspQ1, suspSync, thermQ1, thermSync;
  logic [2:0] addrQ1, addrQ2;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      {sclQ1, sclQ2, sclQ3} <= 3'h7;
      {sdaQ1, sdaQ2, sdaQ3} <= 3'h7;
      {suspQ1, suspSync} <= 2'h3;
      {thermQ1, thermSync} <= 2'h0;
      addrQ1 <= 3'h0;
      addrQ2 <= 3'h0;
    end else begin
      {sclQ1, sclQ2, sclQ3} <= {sclIn, sclQ1, sclQ2};
      {sdaQ1, sdaQ2, sdaQ3} <= {sdaIn, sdaQ1, sdaQ2};
      {suspQ1, suspSync} <= {bank_select_suspend_n, suspQ1};
      {thermQ1, thermSync} <= {thermalShutdown, thermQ1};
      addrQ1 <= addrSelect;
      addrQ2 <= addrQ1;
    end
  end

  // bus conditions, all from the second stage onward
  wire sclRise = sclQ2 & ~sclQ3;
  wire sclFall = ~sclQ2 & sclQ3;
  wire startCond = sclQ2 & sclQ3 & sdaQ3 & ~sdaQ2;
  wire stopCond = sclQ2 & sclQ3 & ~sdaQ3 & sdaQ2;

  // pin edges
  logic [WIDTH-1:0] pinLevel, riseEv, fallEv;
  pin_edge_detect #(.WIDTH(WIDTH)) edges (
    .mclk(mclk),
    .rstN(rstN),
    .pinRaw(ioIn),
    .pinLevel(pinLevel),
    .riseEv(riseEv),
    .fallEv(fallEv)
  );

  // register file storage
  logic [7:0] regs [NUM_REGS];
  bus_state_e state;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn, txShift, cmdByte, pointer;
  logic isRead, araMode, cmdHeld, alertPending;
  logic [6:0] slaveAddr;
  logic [1:0] initCnt;

  // write decode: one-shot and id codes land in normal output state; pin level and unknown codes go nowhere
  function automatic logic [2:0] writeIndex(input logic [7:0] cmd);
    if (cmd <= CMD_SUSPEND_FALL)
      return cmd[2:0];
    else if (cmd == CMD_ADDR_RESAMPLE || cmd == CMD_SW_RESET || cmd == CMD_MAKER_ID)
      return IDX_NORMAL_OUT;
    else
      return IDX_NONE;
  endfunction

  // read decode
  function automatic logic [7:0] readValue(input logic [7:0] cmd);
    if (cmd <= CMD_SUSPEND_FALL)
      return regs[cmd[2:0]];
    else if (cmd == CMD_PIN_LEVEL)
      return pinLevel;
    else if (cmd == CMD_MAKER_ID)
      return MAKER_ID;
    else
      return 8'h00;
  endfunction

  // transaction events
  wire byteDone = sclFall && (bitCnt == BITS_PER_BYTE);
  wire addrHit = (shiftIn[7:1] == slaveAddr);
  wire araHit = (shiftIn[7:1] == ALERT_RESP_ADDR) && shiftIn[0] && alertPending;
  wire writeEv = (state == ST_DATA) && byteDone && !startCond && !stopCond;
  wire cmdEv = (state == ST_CMD) && byteDone && !startCond && !stopCond;
  wire cmdClose = cmdHeld && (startCond || stopCond || writeEv);
  wire resampleEv = cmdClose && (cmdByte == CMD_ADDR_RESAMPLE || cmdByte == CMD_SW_RESET);
  wire swResetEv = cmdClose && (cmdByte == CMD_SW_RESET);
  wire araDone = (state == ST_TX) && byteDone && araMode;
  wire arbLost = (state == ST_TX) && sclRise && !sdaOe && !sdaQ2;
  wire [2:0] wrIdx = writeIndex(cmdByte);
  wire [7:0] txLoad = araMode ? {slaveAddr, 1'b0} : readValue(pointer);

  // bank selection tracks the pin, never the bus
  wire [7:0] activeState = suspSync ? regs[IDX_NORMAL_OUT] : regs[IDX_SUSPEND_OUT];
  wire [7:0] riseMask = regs[IDX_NORMAL_RISE];
  wire [7:0] fallMask = suspSync ? regs[IDX_NORMAL_FALL] : regs[IDX_SUSPEND_FALL];
  wire pinAlert = |(riseEv & ~riseMask) | |(fallEv & ~fallMask);
  wire clearEv = araDone | swResetEv;
  wire next_pending = (alertPending & ~clearEv) | pinAlert | thermSync;

  // bit-level slave engine
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txShift <= 8'h00;
      isRead <= 1'b0;
      araMode <= 1'b0;
      sdaOe <= 1'b0;
    end else if (startCond) begin
      state <= ST_ADDR;
      bitCnt <= 4'h0;
      sdaOe <= 1'b0;
    end else if (stopCond) begin
      state <= ST_IDLE;
      sdaOe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (sclRise) begin
            shiftIn <= {shiftIn[6:0], sdaQ2};
            bitCnt <= bitCnt + 4'h1;
          end else if (byteDone) begin
            bitCnt <= 4'h0;
            sdaOe <= 1'b1;
            if (state == ST_ADDR) begin
              isRead <= shiftIn[0];
              araMode <= araHit;
              state <= (addrHit || araHit) ? ST_ADDR_ACK : ST_SKIP;
              sdaOe <= addrHit || araHit;
            end else begin
              state <= (state == ST_CMD) ? ST_CMD_ACK : ST_DATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall && isRead) begin
            state <= ST_TX;
            txShift <= txLoad;
            sdaOe <= ~txLoad[7];
          end else if (sclFall) begin
            state <= ST_CMD;
            sdaOe <= 1'b0;
          end
        end
        ST_CMD_ACK: begin
          if (sclFall) begin
            state <= ST_DATA;
            sdaOe <= 1'b0;
          end
        end
        ST_TX: begin
          if (arbLost) begin
            state <= ST_SKIP;
          end else if (sclRise) begin
            bitCnt <= bitCnt + 4'h1;
          end else if (byteDone) begin
            state <= ST_TX_ACK;
            sdaOe <= 1'b0;
          end else if (sclFall) begin
            txShift <= {txShift[6:0], 1'b0};
            sdaOe <= ~txShift[6];
          end
        end
        ST_DATA_ACK, ST_TX_ACK: begin
          // one byte per transaction; later bytes are not acknowledged
          if (sclFall) begin
            state <= ST_SKIP;
            sdaOe <= 1'b0;
          end
        end
        ST_IDLE, ST_SKIP: begin
          sdaOe <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // command held until the transaction shows its form
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cmdByte <= 8'h00;
      cmdHeld <= 1'b0;
      pointer <= 8'h00;
    end else begin
      if (cmdEv) begin
        cmdByte <= shiftIn;
        cmdHeld <= 1'b1;
      end else if (cmdClose) begin
        cmdHeld <= 1'b0;
      end
      if (cmdHeld && (startCond || writeEv))
        pointer <= cmdByte;
    end
  end

  // register file; alert response reads touch none of it, a data byte beats a soft reset
  genvar i;
  generate
    for (i = 0; i < NUM_REGS; i++) begin : g_reg
      localparam logic [7:0] RST_VAL = (i == 0 || i == 3) ? OUT_RST : MASK_RST;
      always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
          regs[i] <= RST_VAL;
        else if (writeEv && wrIdx == 3'(i))
          regs[i] <= shiftIn;
        else if (swResetEv)
          regs[i] <= RST_VAL;
      end
    end
  endgenerate

  // slave address taken shortly after release and by resample commands
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      initCnt <= ADDR_SAMPLE_DELAY;
      slaveAddr <= SLAVE_ADDR_BASE;
    end else begin
      if (initCnt != 2'h0)
        initCnt <= initCnt - 2'h1;
      if (initCnt == 2'h1 || resampleEv)
        slaveAddr <= SLAVE_ADDR_BASE + {4'h0, addrQ2};
    end
  end

  // pins and alert, all registered; thermal shutdown releases every expander pin
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      alertPending <= 1'b0;
      alertN <= 1'b1;
      ioOe <= ~OUT_RST;
      ioOut <= '0;
      sdaOut <= 1'b0;
    end else begin
      alertPending <= next_pending;
      alertN <= ~next_pending;
      ioOe <= ~activeState & {WIDTH{~thermSync}};
      ioOut <= '0;
      sdaOut <= 1'b0;
    end
  end

  // checks
  property p_pin_drive;
    @(posedge mclk) disable iff (!rstN)
    !thermSync |=> ioOe == ~$past(activeState);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive mismatch");

  property p_reset_vals;
    @(posedge mclk) $rose(rstN) |-> regs[1] == MASK_RST && regs[5] == MASK_RST
      && regs[0] == OUT_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_bank_sel;
    @(posedge mclk) disable iff (!rstN)
    !suspSync && !thermSync |=> ioOe == ~$past(regs[IDX_SUSPEND_OUT]);
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("suspend bank unused");

  property p_thermal;
    @(posedge mclk) disable iff (!rstN)
    thermSync |=> !alertN && ioOe == '0;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal alert missing");

  property p_rise_alert;
    @(posedge mclk) disable iff (!rstN)
    |(riseEv & ~regs[IDX_NORMAL_RISE]) |=> !alertN [*2];
  endproperty
  a_rise_alert: assert property (p_rise_alert) else $error("edge alert missing");

  property p_hold;
    @(posedge mclk) disable iff (!rstN)
    alertPending && !araDone && !swResetEv |=> alertPending;
  endproperty
  a_hold: assert property (p_hold) else $error("alert cleared early");

  property p_keep_regs;
    @(posedge mclk) disable iff (!rstN)
    araDone && !pinAlert && !thermSync
      |=> $stable(regs[0]) && $stable(regs[2]) && !alertPending;
  endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("clear changed regs");

  property p_ack_low;
    @(posedge mclk) disable iff (!rstN)
    state == ST_CMD_ACK && $past(state) == ST_CMD |-> sdaOe && !sdaOut;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven low");

  property p_arb;
    @(posedge mclk) disable iff (!rstN)
    arbLost |=> state == ST_SKIP && !sdaOe ##1 alertPending;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss mishandled");

  c_ara: cover property (@(posedge mclk) disable iff (!rstN) araDone);
  c_write: cover property (@(posedge mclk) disable iff (!rstN) writeEv);
  c_sw_reset: cover property (@(posedge mclk) disable iff (!rstN) swResetEv);
endmodule
`default_nettype wire

// *** tb/smbus_host_model.sv ***
// smbus host controller model that drives the expander's bus pins
`default_nettype none
module smbus_host_model (
  // clock
  input wire logic mclk,
  // device pull on the data line
  input wire logic devSdaOe,
  // bus pins as the device sees them
  output logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hostSda = 1'b1;
  int slow = 0;
  // wired-and with pull-up, so a released line reads high
  assign sda = hostSda & ~devSdaOe;
  initial scl = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one bit: data moves in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic got);
    hostSda <= b;
    tick(2 + slow); // slow host stretches the low phase
    scl <= 1'b1;
    tick(2);
    got = sda;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    hostSda <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    hostSda <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    hostSda <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    hostSda <= 1'b1;
    tick(6);
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic hostAck,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(hostAck, ack); // released high means no acknowledge
  endtask
endmodule
`default_nettype wire

// *** tb/smbus_io_expander_tb_top.sv ***
// self-checking bench for the dual-bank smbus i/o expander
`default_nettype none
module smbus_io_expander_tb_top import ioexp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary value
  localparam logic [7:0] MCMD [4] = '{8'h02, 8'h05, 8'h01, 8'h01};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic susN = 1'b1;
  logic hot = 1'b0;
  logic [2:0] addrSel = 3'h2;
  logic [7:0] pinExt = 8'hff;
  logic [7:0] ioOe;
  logic sdaOe;
  logic alertN;
  logic [7:0] ioOut;
  logic sdaOut;
  wire scl;
  wire sda;
  // open-drain pins with external pull-ups
  wire [7:0] ioPin = pinExt & ~ioOe;
  int nFail = 0;
  int checkCount = 0;
  int seed = 32'hda88;
  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  smbus_io_expander #(.WIDTH(8), .PCHAN_VARIANT(1'b0), .MAKER_ID(ID_CODE)) uut (
    .mclk(mclk), .resetn(resetn), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .ioIn(ioPin), .ioOut(ioOut), .ioOe(ioOe), .bank_select_suspend_n(susN),
    .addrSelect(addrSel), .thermalShutdown(hot), .alertN(alertN));
  smbus_host_model host (.mclk(mclk), .devSdaOe(sdaOe), .scl(scl), .sda(sda));
  function automatic logic [6:0] slaveOf(input logic [2:0] s);
    return SLAVE_ADDR_BASE + 7'(s);
  endfunction
  function automatic logic [7:0] resetVal(input int i);
    return (i % 3 == 0) ? OUT_RST_NCHAN : MASK_RST;
  endfunction
  task automatic checkByte(input logic [7:0] got, input logic [7:0] want);
    checkCount++;
    if (got !== want) begin
      nFail++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, want);
    end
  endtask
  task automatic checkBit(input logic got, input logic want);
    checkByte({7'h0, got}, {7'h0, want});
  endtask
  task automatic endTest(input string s);
    $display("%s finished, %0d failures so far", s, nFail);
  endtask
  task automatic give_verdict();
    $display("checks %0d, failures %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait on pin drive (oe) or alert level
  task automatic waitFor(input bit oe, input logic [7:0] want);
    int n;
    n = 0;
    while ((oe ? ioOe : {7'h0, alertN}) !== want && n < 60) begin
      @(posedge mclk);
      n++;
    end
    checkByte(oe ? ioOe : {7'h0, alertN}, want);
    if ((oe ? ioOe : {7'h0, alertN}) !== want) give_verdict();
  endtask
  // kind: 0 write-byte, 1 send-byte, 2 read-byte, 3 receive-byte
  task automatic txn(input logic [6:0] a, input int kind, input logic [7:0] cmd,
                     input logic [7:0] wd, output logic [7:0] rd, output logic ack);
    logic [7:0] rx;
    logic a2;
    rd = 8'hff;
    host.start();
    host.byte_io({a, kind == 3}, 1'b1, rx, ack);
    if (kind != 3) host.byte_io(cmd, 1'b1, rx, a2);
    if (kind == 0) host.byte_io(wd, 1'b1, rx, a2);
    if (kind == 2) begin
      host.start();
      host.byte_io({a, 1'b1}, 1'b1, rx, a2);
    end
    // host bits are wired-and with the device; a non-zero wd models a rival responder
    if (kind >= 2) host.byte_io(~wd, 1'b1, rd, a2);
    host.stop(); // send-byte stops right after the command
  endtask
  // main sequence
  initial begin
    logic [7:0] rd;
    logic [7:0] v;
    logic [7:0] regv [6];
    logic ack;
    logic [2:0] b;
    logic [6:0] me;
    me = slaveOf(3'h2);
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (12) @(posedge mclk); // address sampling settles first
    for (int i = 0; i < 6; i++) begin
      txn(me, 2, 8'(i), 8'h0, rd, ack);
      checkByte(rd, resetVal(i));
    end
    checkByte(ioOe, ~OUT_RST_NCHAN);
    checkByte(ioOut | {7'h0, sdaOut}, 8'h00);
    txn(me, 2, CMD_MAKER_ID, 8'h0, rd, ack);
    checkByte(rd, ID_CODE);
    endTest("reset");
    // random contents, host alternating fast and slow
    for (int i = 0; i < 6; i++) begin
      regv[i] = 8'($random(seed));
      host.slow = i % 2;
      txn(me, 0, 8'(i), regv[i], rd, ack);
      checkBit(ack, 1'b0);
    end
    host.slow = 0;
    for (int i = 0; i < 6; i++) begin
      txn(me, 2, 8'(i), 8'h0, rd, ack);
      checkByte(rd, regv[i]);
    end
    txn(me, 3, 8'h0, 8'h0, rd, ack);
    checkByte(rd, regv[5]);
    endTest("registers");
    // bank switch while the bus is idle
    waitFor(1'b1, ~regv[0]);
    susN <= 1'b0;
    waitFor(1'b1, ~regv[3]);
    v = 8'($random(seed));
    pinExt <= v;
    txn(me, 2, CMD_PIN_LEVEL, 8'h0, rd, ack);
    checkByte(rd, v & regv[3]);
    endTest("bank");
    // release and mask everything, clear any leftover alert
    pinExt <= 8'hff;
    for (int i = 0; i < 6; i++) txn(me, 0, 8'(i), 8'hff, rd, ack);
    txn(ALERT_RESP_ADDR, 3, 8'h0, 8'h0, rd, ack);
    pinExt <= 8'h0f;
    repeat (12) @(posedge mclk); // alert would show within ~5 cycles
    checkBit(alertN, 1'b1);
    pinExt <= 8'hff;
    // one edge per mask kind and bank, masked again before service
    for (int k = 0; k < 4; k++) begin
      b = 3'($random(seed));
      susN <= ~k[0];
      pinExt[b] <= ~k[1];
      txn(me, 0, MCMD[k], ~(8'h1 << b), rd, ack);
      pinExt[b] <= k[1];
      waitFor(1'b0, 8'h0);
      txn(me, 0, MCMD[k], 8'hff, rd, ack);
      checkBit(alertN, 1'b0);
      txn(ALERT_RESP_ADDR, 3, 8'h0, 8'hc1, rd, ack); // rival at 1fh answers too
      checkBit(alertN, 1'b0);
      txn(ALERT_RESP_ADDR, 3, 8'h0, 8'h0, rd, ack);
      checkByte(rd, {me, 1'b0});
      waitFor(1'b0, 8'h1);
      pinExt[b] <= 1'b1;
      @(posedge mclk);
    end
    txn(me, 2, CMD_SUSPEND_OUT, 8'h0, rd, ack);
    checkByte(rd, 8'hff);
    endTest("alerts");
    // overheating with every mask set
    hot <= 1'b1;
    waitFor(1'b0, 8'h0);
    hot <= 1'b0;
    v = 8'($random(seed));
    txn(me, 0, CMD_MAKER_ID, v, rd, ack);
    txn(me, 2, CMD_NORMAL_OUT, 8'h0, rd, ack);
    checkByte(rd, v);
    txn(me, 1, CMD_SW_RESET, 8'h0, rd, ack);
    waitFor(1'b0, 8'h1);
    for (int i = 0; i < 6; i++) begin
      txn(me, 2, 8'(i), 8'h0, rd, ack);
      checkByte(rd, resetVal(i));
    end
    txn(me, 0, CMD_NORMAL_RISE, v, rd, ack);
    txn(me, 0, CMD_SW_RESET, ~v, rd, ack);
    txn(me, 2, CMD_NORMAL_OUT, 8'h0, rd, ack);
    checkByte(rd, ~v);
    txn(me, 2, CMD_NORMAL_RISE, 8'h0, rd, ack);
    checkByte(rd, MASK_RST);
    endTest("thermal and reset");
    // new address pins take effect only after resample
    addrSel <= 3'h5;
    txn(me, 1, CMD_ADDR_RESAMPLE, 8'h0, rd, ack);
    txn(slaveOf(3'h5), 2, CMD_NORMAL_OUT, 8'h0, rd, ack);
    checkBit(ack, 1'b0);
    txn(me, 2, CMD_NORMAL_OUT, 8'h0, rd, ack);
    checkBit(ack, 1'b1);
    endTest("address");
    give_verdict();
  end
endmodule
`default_nettype wire
